// >>> hw/status_bank_consts.svh
// Register offsets, field positions, reset values and flag vector layout of the status bank.
`ifndef STATUS_BANK_CONSTS_SVH
`define STATUS_BANK_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register offsets on the register port
// ----------------------------------------------------------------------------
`define ADDR_TIMER_FLAGS   16'h1914
`define ADDR_FIFO_NONEMPTY 16'h1915
`define ADDR_FIFO_FULL     16'h1916
`define ADDR_FIFO_LEVEL    16'h1917
`define ADDR_CORE_DMA      16'h1918
`define ADDR_CORE_START1   16'h191a

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define TIMER_ONE_BIT      0
`define FLAG_WORD_RESET    8'h00
`define READ_IDLE_VALUE    8'h00

// ----------------------------------------------------------------------------
// Layout of the packed flag vector inside the bank
// ----------------------------------------------------------------------------
`define LSB_TIMER          0
`define LSB_NONEMPTY       1
`define LSB_FULL           9
`define LSB_LEVEL          17
`define LSB_DMA            25
`define LSB_START1         32
`define FLAG_TOTAL         39

`endif

// >>> hw/status_bank_pkg.sv
// Shared types of the status bank.
package status_bank_pkg;

  // ----------------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------------
  typedef logic [7:0]  status_word_t;
  typedef logic [15:0] reg_addr_t;
  typedef logic [38:0] flag_vec_t;

endpackage : status_bank_pkg

// >>> hw/edge_flag_bank.sv
// Rising-edge detectors with sticky write-one-to-clear flags, one per source bit.
`timescale 1ns/10ps

module edge_flag_bank #(
  parameter int WIDTH = 39
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] src,
  input  wire logic [WIDTH-1:0] clr,
  output logic      [WIDTH-1:0] flag
);

  // ----------------------------------------------------------------------------
  // Edge detection and flag update
  // ----------------------------------------------------------------------------
  logic [WIDTH-1:0] prev_r;
  logic [WIDTH-1:0] flag_r;
  logic [WIDTH-1:0] flag_nxt;

  // The set term is applied after the clear so an edge in a clearing cycle survives.
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      assign flag_nxt[i] = (flag_r[i] & ~clr[i]) | (src[i] & ~prev_r[i]);
    end
  endgenerate

  // Previous source levels start low, so a source already high at release sets its flag.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prev_r <= '0;
      flag_r <= '0;
    end else begin
      prev_r <= src;
      flag_r <= flag_nxt;
    end
  end

  assign flag = flag_r;

endmodule : edge_flag_bank

// >>> hw/irq_event_dsp_status_bank.sv
// Second interrupt bank status words for timer one, event-log FIFOs and DSP core events.
`timescale 1ns/10ps
`include "status_bank_consts.svh"

module irq_event_dsp_status_bank #(
  parameter int LOGS  = 8,
  parameter int CORES = 7
) (
  input  wire logic                           clk,
  input  wire logic                           resetn,
  input  wire status_bank_pkg::reg_addr_t     reg_addr,
  input  wire logic                           reg_wr,
  input  wire status_bank_pkg::status_word_t  reg_wdata,
  input  wire logic                           reg_rd,
  output status_bank_pkg::status_word_t       reg_rdata,
  output logic                                reg_rvalid,
  input  wire logic                           timer_one_evt,
  input  wire logic [LOGS-1:0]                log_nonempty,
  input  wire logic [LOGS-1:0]                log_full,
  input  wire logic [LOGS-1:0]                log_level,
  input  wire logic [CORES-1:0]               core_dma,
  input  wire logic [CORES-1:0]               core_start_one,
  output logic                                timer_one_flag,
  output logic [LOGS-1:0]                     log_fifo_nonempty_flag,
  output logic [LOGS-1:0]                     log_fifo_full_flag,
  output logic [LOGS-1:0]                     log_fifo_level_flag,
  output logic [CORES-1:0]                    core_dma_flag,
  output logic [CORES-1:0]                    core_start_one_flag
);

  // ----------------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------------
  logic hit_timer;
  logic hit_nonempty;
  logic hit_full;
  logic hit_level;
  logic hit_dma;
  logic hit_start1;
  logic hit_any;

  // Each status word has its own offset; anything else reads as zero and ignores writes.
  assign hit_timer    = (reg_addr == `ADDR_TIMER_FLAGS);
  assign hit_nonempty = (reg_addr == `ADDR_FIFO_NONEMPTY);
  assign hit_full     = (reg_addr == `ADDR_FIFO_FULL);
  assign hit_level    = (reg_addr == `ADDR_FIFO_LEVEL);
  assign hit_dma      = (reg_addr == `ADDR_CORE_DMA);
  assign hit_start1   = (reg_addr == `ADDR_CORE_START1);
  assign hit_any      = hit_timer | hit_nonempty | hit_full | hit_level | hit_dma | hit_start1;

  // ----------------------------------------------------------------------------
  // Source and clear vectors
  // ----------------------------------------------------------------------------
  status_bank_pkg::flag_vec_t src_all;
  status_bank_pkg::flag_vec_t clr_all;
  status_bank_pkg::flag_vec_t flag_all;

  // All sources travel as one packed vector so a single bank instance serves every word.
  assign src_all = {core_start_one, core_dma, log_level, log_full, log_nonempty, timer_one_evt};

  // Only the written word's bits that carry a one clear; zero bits pass untouched.
  assign clr_all[`LSB_TIMER]            = reg_wr & hit_timer & reg_wdata[`TIMER_ONE_BIT];
  assign clr_all[`LSB_NONEMPTY +: LOGS] = (reg_wr & hit_nonempty) ? reg_wdata[LOGS-1:0] : '0;
  assign clr_all[`LSB_FULL +: LOGS]     = (reg_wr & hit_full) ? reg_wdata[LOGS-1:0] : '0;
  assign clr_all[`LSB_LEVEL +: LOGS]    = (reg_wr & hit_level) ? reg_wdata[LOGS-1:0] : '0;
  assign clr_all[`LSB_DMA +: CORES]     = (reg_wr & hit_dma) ? reg_wdata[CORES-1:0] : '0;
  assign clr_all[`LSB_START1 +: CORES]  = (reg_wr & hit_start1) ? reg_wdata[CORES-1:0] : '0;

  // ----------------------------------------------------------------------------
  // Sticky flag bank
  // ----------------------------------------------------------------------------
  // Edges latch into sticky flags; the set term beats a same-cycle clear.
  edge_flag_bank #(
    .WIDTH (`FLAG_TOTAL)
  ) u_flags (
    .clk    (clk),
    .resetn (resetn),
    .src    (src_all),
    .clr    (clr_all),
    .flag   (flag_all)
  );

  assign timer_one_flag         = flag_all[`LSB_TIMER];
  assign log_fifo_nonempty_flag = flag_all[`LSB_NONEMPTY +: LOGS];
  assign log_fifo_full_flag     = flag_all[`LSB_FULL +: LOGS];
  assign log_fifo_level_flag    = flag_all[`LSB_LEVEL +: LOGS];
  assign core_dma_flag          = flag_all[`LSB_DMA +: CORES];
  assign core_start_one_flag    = flag_all[`LSB_START1 +: CORES];

  // ----------------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------------
  status_bank_pkg::status_word_t rd_word;
  status_bank_pkg::status_word_t rdata_r;
  logic                          rvalid_r;

  // Unused upper bits read as zero; the timer word only carries bit 0 in this bank.
  assign rd_word = hit_timer    ? status_bank_pkg::status_word_t'({7'h00, timer_one_flag}) :
                   hit_nonempty ? status_bank_pkg::status_word_t'(log_fifo_nonempty_flag) :
                   hit_full     ? status_bank_pkg::status_word_t'(log_fifo_full_flag) :
                   hit_level    ? status_bank_pkg::status_word_t'(log_fifo_level_flag) :
                   hit_dma      ? status_bank_pkg::status_word_t'(core_dma_flag) :
                   hit_start1   ? status_bank_pkg::status_word_t'(core_start_one_flag) :
                   `READ_IDLE_VALUE;

  // Read data is held until the next read so software may sample it late.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_r  <= `FLAG_WORD_RESET;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= reg_rd;
      if (reg_rd) begin
        rdata_r <= rd_word;
      end
    end
  end

  assign reg_rdata  = rdata_r;
  assign reg_rvalid = rvalid_r;

  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  sequence s_timer_rise;
    timer_one_evt && !$past(timer_one_evt);
  endsequence

  sequence s_read_timer;
    reg_rd && hit_timer ##1 reg_rvalid;
  endsequence

  sequence s_clear_full_no_edge;
    reg_wr && hit_full && ((log_full & ~$past(log_full)) == '0);
  endsequence

  sequence s_clear_dma_with_edge;
    reg_wr && hit_dma && ((core_dma & ~$past(core_dma) & reg_wdata[CORES-1:0]) != '0);
  endsequence

  property p_timer_set;
    @(posedge clk) disable iff (!resetn)
    s_timer_rise |=> timer_one_flag ##1 (timer_one_flag || $past(clr_all[`LSB_TIMER]));
  endproperty
  a_timer_set: assert property (p_timer_set) else $error("timer one flag not latched");

  property p_nonempty_set;
    @(posedge clk) disable iff (!resetn)
    (|(log_nonempty & ~$past(log_nonempty))) |=>
      ((log_fifo_nonempty_flag & $past(log_nonempty & ~$past(log_nonempty)))
       == $past(log_nonempty & ~$past(log_nonempty)));
  endproperty
  a_nonempty_set: assert property (p_nonempty_set) else $error("nonempty flag missed an edge");

  property p_full_set;
    @(posedge clk) disable iff (!resetn)
    (|(log_full & ~$past(log_full))) |=>
      ((log_fifo_full_flag & $past(log_full & ~$past(log_full))) == $past(log_full & ~$past(log_full)));
  endproperty
  a_full_set: assert property (p_full_set) else $error("full flag missed an edge");

  property p_level_set;
    @(posedge clk) disable iff (!resetn)
    (|(log_level & ~$past(log_level))) |=>
      ((log_fifo_level_flag & $past(log_level & ~$past(log_level))) == $past(log_level & ~$past(log_level)));
  endproperty
  a_level_set: assert property (p_level_set) else $error("watermark flag missed an edge");

  property p_dma_set;
    @(posedge clk) disable iff (!resetn)
    (|(core_dma & ~$past(core_dma))) |=>
      ((core_dma_flag & $past(core_dma & ~$past(core_dma))) == $past(core_dma & ~$past(core_dma)));
  endproperty
  a_dma_set: assert property (p_dma_set) else $error("dma flag missed an edge");

  property p_start1_stable;
    @(posedge clk) disable iff (!resetn)
    ((core_start_one & ~$past(core_start_one)) == '0) && !(reg_wr && hit_start1) |=>
      (core_start_one_flag == $past(core_start_one_flag));
  endproperty
  a_start1_stable: assert property (p_start1_stable) else $error("start-one flag moved without cause");

  property p_full_clear;
    @(posedge clk) disable iff (!resetn)
    s_clear_full_no_edge |=>
      ((log_fifo_full_flag & $past(reg_wdata[LOGS-1:0])) == '0) &&
      ((log_fifo_full_flag & ~$past(reg_wdata[LOGS-1:0])) ==
       ($past(log_fifo_full_flag) & ~$past(reg_wdata[LOGS-1:0])));
  endproperty
  a_full_clear: assert property (p_full_clear) else $error("write-one clear of full word wrong");

  property p_reset_zero;
    @(posedge clk)
    !resetn |-> (flag_all == '0) && (reg_rvalid == 1'b0);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("flags not zero in reset");

  property p_edge_beats_clear;
    @(posedge clk) disable iff (!resetn)
    s_clear_dma_with_edge |=>
      ((core_dma_flag & $past(core_dma & ~$past(core_dma) & reg_wdata[CORES-1:0]))
       == $past(core_dma & ~$past(core_dma) & reg_wdata[CORES-1:0]));
  endproperty
  a_edge_beats_clear: assert property (p_edge_beats_clear) else $error("clear lost a same-cycle edge");

  // A write to an address outside the bank must leave every flag alone, or a stray write could drop an event.
  property p_unmapped_write;
    @(posedge clk) disable iff (!resetn)
    reg_wr && !hit_any && ((src_all & ~$past(src_all)) == '0) |=> (flag_all == $past(flag_all));
  endproperty
  a_unmapped_write: assert property (p_unmapped_write) else $error("unmapped write moved a flag");

  property p_read_timer;
    @(posedge clk) disable iff (!resetn)
    s_read_timer |-> (reg_rdata == {7'h00, $past(timer_one_flag)});
  endproperty
  a_read_timer: assert property (p_read_timer) else $error("timer word read back wrong");

endmodule : irq_event_dsp_status_bank

// >>> test/irq_event_dsp_status_bank_tb_top.sv
// Self-checking testbench for the second interrupt bank event, FIFO and DSP status words.
`timescale 1ns/10ps
`include "status_bank_consts.svh"

module irq_event_dsp_status_bank_tb_top;
  logic                          clk;
  logic                          resetn;
  status_bank_pkg::reg_addr_t    reg_addr;
  logic                          reg_wr;
  status_bank_pkg::status_word_t reg_wdata;
  logic                          reg_rd;
  status_bank_pkg::status_word_t reg_rdata;
  logic                          reg_rvalid;
  status_bank_pkg::flag_vec_t    src;
  status_bank_pkg::flag_vec_t    mdl;
  status_bank_pkg::flag_vec_t    flags;
  int                            failures;
  int                            comparisons;
  status_bank_pkg::reg_addr_t    addrs [6] = '{`ADDR_TIMER_FLAGS, `ADDR_FIFO_NONEMPTY, `ADDR_FIFO_FULL,
                                               `ADDR_FIFO_LEVEL, `ADDR_CORE_DMA, `ADDR_CORE_START1};
  int                            lsbs  [6] = '{`LSB_TIMER, `LSB_NONEMPTY, `LSB_FULL,
                                               `LSB_LEVEL, `LSB_DMA, `LSB_START1};
  int                            widths[6] = '{1, 8, 8, 8, 7, 7};

  // ----------------------------------------------------------------------------
  // Device under test
  // ----------------------------------------------------------------------------
  // All sources come from one packed vector laid out like the bank, so one model vector covers every flag.
  irq_event_dsp_status_bank i_dut (
    .clk                    (clk),
    .resetn                 (resetn),
    .reg_addr               (reg_addr),
    .reg_wr                 (reg_wr),
    .reg_wdata              (reg_wdata),
    .reg_rd                 (reg_rd),
    .reg_rdata              (reg_rdata),
    .reg_rvalid             (reg_rvalid),
    .timer_one_evt          (src[`LSB_TIMER]),
    .log_nonempty           (src[`LSB_NONEMPTY +: 8]),
    .log_full               (src[`LSB_FULL +: 8]),
    .log_level              (src[`LSB_LEVEL +: 8]),
    .core_dma               (src[`LSB_DMA +: 7]),
    .core_start_one         (src[`LSB_START1 +: 7]),
    .timer_one_flag         (flags[`LSB_TIMER]),
    .log_fifo_nonempty_flag (flags[`LSB_NONEMPTY +: 8]),
    .log_fifo_full_flag     (flags[`LSB_FULL +: 8]),
    .log_fifo_level_flag    (flags[`LSB_LEVEL +: 8]),
    .core_dma_flag          (flags[`LSB_DMA +: 7]),
    .core_start_one_flag    (flags[`LSB_START1 +: 7])
  );

  // ----------------------------------------------------------------------------
  // Clock, compare and access tasks
  // ----------------------------------------------------------------------------
  // The clock runs at 20 MHz.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic final_report();
    if (failures == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report

  task automatic cmp_word(input status_bank_pkg::status_word_t got, input status_bank_pkg::status_word_t exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_word

  task automatic cmp_vec(input status_bank_pkg::flag_vec_t got, input status_bank_pkg::flag_vec_t exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_vec

  // Each access takes two cycles so a strobe is never lowered and raised in one time step.
  task automatic wr(input status_bank_pkg::reg_addr_t a, input status_bank_pkg::status_word_t d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk); #1;
    reg_wr = 1'b0;
    @(posedge clk); #1;
  endtask : wr

  task automatic rd(input status_bank_pkg::reg_addr_t a, input status_bank_pkg::status_word_t exp);
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk); #1;
    reg_rd = 1'b0;
    cmp_word({7'h00, reg_rvalid}, 8'h01);
    cmp_word(reg_rdata, exp);
    @(posedge clk); #1;
    cmp_word({7'h00, reg_rvalid}, 8'h00);
  endtask : rd

  // Writes a clear mask to word k and removes the same bits from the model.
  task automatic clr(input int k, input status_bank_pkg::status_word_t d);
    status_bank_pkg::flag_vec_t m;
    m = (39'(d) & ((39'h1 << widths[k]) - 39'h1)) << lsbs[k];
    wr(addrs[k], d);
    mdl = mdl & ~m;
  endtask : clr

  task automatic check_all();
    status_bank_pkg::flag_vec_t w;
    cmp_vec(flags, mdl);
    for (int k = 0; k < 6; k++) begin
      w = (mdl >> lsbs[k]) & ((39'h1 << widths[k]) - 39'h1);
      rd(addrs[k], w[7:0]);
    end
  endtask : check_all

  // A source edge and a clearing write land on the same edge; the flag must survive.
  task automatic clash(input int k, input int i);
    reg_addr = addrs[k];
    reg_wdata = 8'h01 << (i - lsbs[k]);
    reg_wr = 1'b1;
    src[i] = 1'b1;
    @(posedge clk); #1;
    reg_wr = 1'b0;
    src[i] = 1'b0;
    @(posedge clk); #1;
    mdl[i] = 1'b1;
    cmp_vec(flags, mdl);
  endtask : clash

  // ----------------------------------------------------------------------------
  // Watchdog and main sequence
  // ----------------------------------------------------------------------------
  // The tests need about 1200 cycles; twenty thousand leaves a wide margin.
  initial begin
    #1000000;
    failures++;
    final_report();
  end

  initial begin
    {reg_addr, reg_wr, reg_wdata, reg_rd} = '0;
    src = '0;
    mdl = '0;
    resetn = 1'b0;
    repeat (5) @(posedge clk);
    #1 resetn = 1'b1;
    check_all();
    rd(16'h1919, 8'h00);
    // Walk every source alone so each bit position is proved.
    for (int i = 0; i < `FLAG_TOTAL; i++) begin
      src[i] = 1'b1;
      @(posedge clk); #1;
      src[i] = 1'b0;
      mdl[i] = 1'b1;
      @(posedge clk); #1;
      check_all();
      for (int k = 0; k < 6; k++) clr(k, 8'hff);
    end
    check_all();
    // All sources high together, then an unmapped write and zero writes.
    src = '1;
    mdl = '1;
    repeat (2) @(posedge clk); #1;
    wr(16'h1919, 8'hff);
    for (int k = 0; k < 6; k++) wr(addrs[k], 8'h00);
    check_all();
    clr(1, 8'h55);
    clr(4, 8'h2a);
    check_all();
    // Steady high levels and falling edges must not set anything again.
    for (int k = 0; k < 6; k++) clr(k, 8'hff);
    check_all();
    src = '0;
    repeat (2) @(posedge clk); #1;
    check_all();
    clash(0, `LSB_TIMER);
    clash(5, `LSB_START1 + 6);
    clash(2, `LSB_FULL + 7);
    clash(4, `LSB_DMA + 3);
    check_all();
    // Reset in mid-run clears every flag.
    resetn = 1'b0;
    @(posedge clk); #1;
    cmp_vec(flags, '0);
    resetn = 1'b1;
    mdl = '0;
    check_all();
    final_report();
  end
endmodule : irq_event_dsp_status_bank_tb_top
